// ===== cpg_pkg.sv
// Package of constants and types for the complementary PWM output generator
`default_nettype none
package cpg_pkg;

   // ****************************************************************
   // Register byte offsets
   // ****************************************************************
   localparam logic [5:0] CPG_OFF_CTRL0 = 6'h00;
   localparam logic [5:0] CPG_OFF_CTRL1 = 6'h04;
   localparam logic [5:0] CPG_OFF_RISE_SEL = 6'h08;
   localparam logic [5:0] CPG_OFF_RISE_EDGE = 6'h0c;
   localparam logic [5:0] CPG_OFF_FALL_SEL = 6'h10;
   localparam logic [5:0] CPG_OFF_FALL_EDGE = 6'h14;
   localparam logic [5:0] CPG_OFF_STEER = 6'h18;
   localparam logic [5:0] CPG_OFF_DB_RISE = 6'h1c;
   localparam logic [5:0] CPG_OFF_DB_FALL = 6'h20;
   localparam logic [5:0] CPG_OFF_BLK_RISE = 6'h24;
   localparam logic [5:0] CPG_OFF_BLK_FALL = 6'h28;
   localparam logic [5:0] CPG_OFF_PH_RISE = 6'h2c;
   localparam logic [5:0] CPG_OFF_PH_FALL = 6'h30;
   localparam logic [5:0] CPG_OFF_SHDN = 6'h34;
   localparam logic [5:0] CPG_OFF_STATUS = 6'h38;

   // ****************************************************************
   // Field positions and reset values
   // ****************************************************************
   localparam int CPG_STAT_SHUT_BIT = 0;
   localparam logic [7:0] CPG_RST_CTRL0 = 8'h00;
   localparam logic [7:0] CPG_RST_CTRL1 = 8'h00;
   localparam logic [7:0] CPG_RST_STEER = 8'h00;
   localparam logic [15:0] CPG_RST_SHDN = 16'h0000;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CPG_CLK_NS = 25;
   localparam int CPG_DELAY_ELEM_NS = 5;
   localparam int CPG_ELEMS_PER_CYC = CPG_CLK_NS / CPG_DELAY_ELEM_NS;
   localparam logic [2:0] CPG_INSTR_DIV = 3'h4;
   localparam logic [2:0] CPG_HFOSC_DIV = 3'h5;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [2:0] {
      CPG_MD_STEER = 3'h0,
      CPG_MD_SYNC_STEER = 3'h1,
      CPG_MD_FB_FWD = 3'h2,
      CPG_MD_FB_REV = 3'h3,
      CPG_MD_HALF = 3'h4,
      CPG_MD_PUSH_PULL = 3'h5
   } cpg_mode_t;

   typedef enum logic [1:0] {
      CPG_OVR_HIZ = 2'h0,
      CPG_OVR_INACTIVE = 2'h1,
      CPG_OVR_LOW = 2'h2,
      CPG_OVR_HIGH = 2'h3
   } cpg_ovr_t;

   typedef struct packed {
      logic en;
      logic [1:0] rsvd;
      logic [1:0] clk_sel;
      logic [2:0] mode;
   } cpg_ctrl0_t;

   typedef struct packed {
      logic [1:0] rsvd;
      logic fall_db_async;
      logic rise_db_async;
      logic [3:0] pol;
   } cpg_ctrl1_t;

   typedef struct packed {
      logic [3:0] static_lvl;
      logic [3:0] steer_en;
   } cpg_steer_t;

   typedef struct packed {
      logic [7:0] ovr;
      logic [1:0] rsvd;
      logic sw_shut;
      logic auto_restart;
      logic [3:0] src_sel;
   } cpg_shdn_t;

endpackage
`default_nettype wire

// ===== cpg_event_in.sv
// One event source: synchroniser plus edge or level detection
`default_nettype none
module cpg_event_in
   import cpg_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic src_i,
   input wire logic edge_i,
   input wire logic fall_i,
   output logic evt_o
);
   logic s1_r;
   logic s2_r;
   logic s3_r;
   logic act;
   logic prev;

   // Two-stage synchroniser, third stage only for edge detection
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
      end else begin
         s1_r <= src_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // Falling sources sense the low level or the high-to-low edge
   assign act = s2_r ^ fall_i;
   assign prev = s3_r ^ fall_i;
   assign evt_o = edge_i ? (act & ~prev) : act;
endmodule
`default_nettype wire

// ===== cpg_delay_timer.sv
// Down-counting delay timer for phase delay, dead band and blanking
`default_nettype none
module cpg_delay_timer
   import cpg_pkg::*;
#(
   parameter int CNT_W = 8
)(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire logic abort_i,
   input wire logic tick_i,
   input wire logic [CNT_W-1:0] len_i,
   output logic busy_o,
   output logic done_o
);
   logic busy_r;
   logic [CNT_W-1:0] cnt_r;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         busy_r <= 1'b0;
         cnt_r <= '0;
      end else if (abort_i) begin
         busy_r <= 1'b0;
      end else if (start_i) begin
         busy_r <= (len_i != '0);
         cnt_r <= len_i;
      end else if (busy_r && tick_i) begin
         cnt_r <= cnt_r - 1'b1;
         if (cnt_r == CNT_W'(1)) begin
            busy_r <= 1'b0;
         end
      end
   end

   // A zero length finishes in the start cycle
   assign busy_o = busy_r;
   assign done_o = ~abort_i & (start_i ? (len_i == '0)
                                       : (busy_r & tick_i & (cnt_r == CNT_W'(1))));
endmodule
`default_nettype wire

// ===== cpg_generator.sv
// Complementary PWM output generator with Avalon-MM register slave
// What this block does
// - Rising rate sets frequency, rise-to-fall sets duty
// - Same or asynchronous sources accepted for events
// - Timers use selectable clock; async dead band
// - Cleared steering enable drives static level bit
// - Steered mode; steering applies next cycle
// - Sync steered: steering waits for rising event
// - Mode codes 000 through 101 as listed
// - Full bridge: one modulated, one fully on
// - Direction change inserts dead band before modulation
// - Forward: D modulated, A held on
// - Reverse: B modulated, C held on
// - Half bridge: two complementary outputs follow input
// - Dead interval before each off-to-on transition
// - Primary to A/C, complement to B/D
// - Push-pull: A=C, B=D, pairs alternate
// - Drive rise to fall; each rise switches pair
// - Optional blanking of opposite event inputs
// - Optional phase delay from rising event
// - Fault shutdown, auto-restart, per-pin override levels
// - Per-source select, edge/level; per-output polarity
// - Disabled or fresh: primary off, complement on
// - Rise: phase, clear complement, blank, dead band, set
// - Fall: phase, clear primary, blank, dead band, set complement
// - Selected sources ORed into each event
`default_nettype none
module cpg_generator
   import cpg_pkg::*;
#(
   parameter int NUM_SRC = 8,
   parameter int NUM_SHD = 4,
   parameter int CNT_W = 8
)(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [5:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic [NUM_SRC-1:0] rise_src_i,
   input wire logic [NUM_SRC-1:0] fall_src_i,
   input wire logic [NUM_SHD-1:0] shdn_src_i,
   output logic [3:0] out_o,
   output logic [3:0] out_oe_n_o
);

   // ****************************************************************
   // Registers and bus slave
   // ****************************************************************
   cpg_ctrl0_t ctrl0_r;
   cpg_ctrl1_t ctrl1_r;
   cpg_steer_t steer_r;
   cpg_shdn_t shdn_r;
   logic [NUM_SRC-1:0] rise_sel_r;
   logic [NUM_SRC-1:0] rise_edge_r;
   logic [NUM_SRC-1:0] fall_sel_r;
   logic [NUM_SRC-1:0] fall_edge_r;
   logic [CNT_W-1:0] db_rise_r;
   logic [CNT_W-1:0] db_fall_r;
   logic [CNT_W-1:0] blk_rise_r;
   logic [CNT_W-1:0] blk_fall_r;
   logic [CNT_W-1:0] ph_rise_r;
   logic [CNT_W-1:0] ph_fall_r;
   logic wait_r;
   logic [31:0] rdata_r;
   logic wr;
   logic [31:0] rd_mux;
   logic [31:0] wmask;
   logic [31:0] wd;
   logic [7:0] status;
   logic clr_shut;

   // State referenced by the status register, plus the output enables
   logic shut_r;
   logic drive_on_r;
   logic prim_r;
   logic comp_r;
   logic [3:0] out_r;
   logic [3:0] oe_n_r;

   assign wr = avs_write_i & ~wait_r;
   assign wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                   {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

   // Merge new write data into old contents by byte lane
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [31:0] m);
      merge = (old_v & ~m) | (new_v & m);
   endfunction

   assign wd = avs_writedata_i;

   // Every request waits exactly one cycle
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wait_r <= 1'b1;
      end else if ((avs_read_i || avs_write_i) && wait_r) begin
         wait_r <= 1'b0;
      end else begin
         wait_r <= 1'b1;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl0_r <= CPG_RST_CTRL0;
         ctrl1_r <= CPG_RST_CTRL1;
         steer_r <= CPG_RST_STEER;
         shdn_r <= CPG_RST_SHDN;
         rise_sel_r <= '0;
         rise_edge_r <= '0;
         fall_sel_r <= '0;
         fall_edge_r <= '0;
         db_rise_r <= '0;
         db_fall_r <= '0;
         blk_rise_r <= '0;
         blk_fall_r <= '0;
         ph_rise_r <= '0;
         ph_fall_r <= '0;
      end else if (wr) begin
         case (avs_address_i)
            CPG_OFF_CTRL0: ctrl0_r <= 8'(merge(32'(ctrl0_r), wd, wmask));
            CPG_OFF_CTRL1: ctrl1_r <= 8'(merge(32'(ctrl1_r), wd, wmask));
            CPG_OFF_RISE_SEL: rise_sel_r <= NUM_SRC'(merge(32'(rise_sel_r), wd, wmask));
            CPG_OFF_RISE_EDGE: rise_edge_r <= NUM_SRC'(merge(32'(rise_edge_r), wd, wmask));
            CPG_OFF_FALL_SEL: fall_sel_r <= NUM_SRC'(merge(32'(fall_sel_r), wd, wmask));
            CPG_OFF_FALL_EDGE: fall_edge_r <= NUM_SRC'(merge(32'(fall_edge_r), wd, wmask));
            CPG_OFF_STEER: steer_r <= 8'(merge(32'(steer_r), wd, wmask));
            CPG_OFF_DB_RISE: db_rise_r <= CNT_W'(merge(32'(db_rise_r), wd, wmask));
            CPG_OFF_DB_FALL: db_fall_r <= CNT_W'(merge(32'(db_fall_r), wd, wmask));
            CPG_OFF_BLK_RISE: blk_rise_r <= CNT_W'(merge(32'(blk_rise_r), wd, wmask));
            CPG_OFF_BLK_FALL: blk_fall_r <= CNT_W'(merge(32'(blk_fall_r), wd, wmask));
            CPG_OFF_PH_RISE: ph_rise_r <= CNT_W'(merge(32'(ph_rise_r), wd, wmask));
            CPG_OFF_PH_FALL: ph_fall_r <= CNT_W'(merge(32'(ph_fall_r), wd, wmask));
            CPG_OFF_SHDN: shdn_r <= 16'(merge(32'(shdn_r), wd, wmask));
            default: ;
         endcase
      end
   end

   assign status = {out_r, comp_r, prim_r, drive_on_r, shut_r};
   assign clr_shut = wr && (avs_address_i == CPG_OFF_STATUS) && avs_byteenable_i[0]
                     && avs_writedata_i[CPG_STAT_SHUT_BIT];

   always_comb begin
      case (avs_address_i)
         CPG_OFF_CTRL0: rd_mux = 32'(ctrl0_r);
         CPG_OFF_CTRL1: rd_mux = 32'(ctrl1_r);
         CPG_OFF_RISE_SEL: rd_mux = 32'(rise_sel_r);
         CPG_OFF_RISE_EDGE: rd_mux = 32'(rise_edge_r);
         CPG_OFF_FALL_SEL: rd_mux = 32'(fall_sel_r);
         CPG_OFF_FALL_EDGE: rd_mux = 32'(fall_edge_r);
         CPG_OFF_STEER: rd_mux = 32'(steer_r);
         CPG_OFF_DB_RISE: rd_mux = 32'(db_rise_r);
         CPG_OFF_DB_FALL: rd_mux = 32'(db_fall_r);
         CPG_OFF_BLK_RISE: rd_mux = 32'(blk_rise_r);
         CPG_OFF_BLK_FALL: rd_mux = 32'(blk_fall_r);
         CPG_OFF_PH_RISE: rd_mux = 32'(ph_rise_r);
         CPG_OFF_PH_FALL: rd_mux = 32'(ph_fall_r);
         CPG_OFF_SHDN: rd_mux = 32'(shdn_r);
         CPG_OFF_STATUS: rd_mux = 32'(status);
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_r <= 32'h0000_0000;
      end else if (avs_read_i && wait_r) begin
         rdata_r <= rd_mux;
      end
   end

   assign avs_readdata_o = rdata_r;
   assign avs_waitrequest_o = wait_r;

   // ****************************************************************
   // Event inputs
   // ****************************************************************
   logic [NUM_SRC-1:0] rise_hit;
   logic [NUM_SRC-1:0] fall_hit;
   logic rise_evt;
   logic fall_evt;

   genvar g;
   generate
      for (g = 0; g < NUM_SRC; g++) begin : g_src
         cpg_event_in u_rise (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .src_i(rise_src_i[g]),
            .edge_i(rise_edge_r[g]),
            .fall_i(1'b0),
            .evt_o(rise_hit[g])
         );
         cpg_event_in u_fall (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .src_i(fall_src_i[g]),
            .edge_i(fall_edge_r[g]),
            .fall_i(1'b1),
            .evt_o(fall_hit[g])
         );
      end
   endgenerate

   assign rise_evt = |(rise_hit & rise_sel_r);
   assign fall_evt = |(fall_hit & fall_sel_r);

   // ****************************************************************
   // Generator timing clock
   // ****************************************************************
   logic [2:0] pre_r;
   logic [2:0] div;
   logic tick;

   always_comb begin
      case (ctrl0_r.clk_sel)
         2'h1: div = CPG_INSTR_DIV;
         2'h2: div = CPG_HFOSC_DIV;
         default: div = 3'h1;
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pre_r <= 3'h0;
      end else if (pre_r >= div - 3'h1) begin
         pre_r <= 3'h0;
      end else begin
         pre_r <= pre_r + 3'h1;
      end
   end

   assign tick = (pre_r == 3'h0);

   // ****************************************************************
   // Timers
   // ****************************************************************
   cpg_mode_t mode;
   logic half;
   logic kill;
   logic rise_trig;
   logic fall_trig;
   logic ph_r_done;
   logic ph_f_done;
   logic db_r_done;
   logic db_f_done;
   logic bk_r_busy;
   logic bk_f_busy;
   logic dir_busy;
   logic dir_start;
   logic [CNT_W-1:0] db_r_len;
   logic [CNT_W-1:0] db_f_len;
   logic [CNT_W-1:0] dir_len;
   logic db_r_tick;
   logic db_f_tick;
   logic dir_tick;
   logic fb_dir_r;
   logic fb;
   logic fb_rev;

   // Delay-chain elements become whole system cycles, rounded up
   function automatic logic [CNT_W-1:0] chain_cyc(input logic [CNT_W-1:0] n);
      chain_cyc = CNT_W'((32'(n) + CPG_ELEMS_PER_CYC - 1) / CPG_ELEMS_PER_CYC);
   endfunction

   assign mode = cpg_mode_t'(ctrl0_r.mode);
   assign half = (mode == CPG_MD_HALF);
   assign fb = (mode == CPG_MD_FB_FWD) || (mode == CPG_MD_FB_REV);
   assign fb_rev = (mode == CPG_MD_FB_REV);
   assign kill = ~ctrl0_r.en | shut_r;

   // Dead band counts only in half bridge
   assign db_r_len = !half ? '0 : ctrl1_r.rise_db_async ? chain_cyc(db_rise_r) : db_rise_r;
   assign db_f_len = !half ? '0 : ctrl1_r.fall_db_async ? chain_cyc(db_fall_r) : db_fall_r;
   assign db_r_tick = ctrl1_r.rise_db_async | tick;
   assign db_f_tick = ctrl1_r.fall_db_async | tick;

   // Blanking ignores the opposite event input
   assign rise_trig = ~kill & rise_evt & ~drive_on_r & ~bk_r_busy;
   assign fall_trig = ~kill & fall_evt & drive_on_r & ~bk_f_busy;

   cpg_delay_timer #(.CNT_W(CNT_W)) u_ph_r (
      .clk_i(clk_i), .rst_i(rst_i), .start_i(rise_trig), .abort_i(kill | fall_trig),
      .tick_i(tick), .len_i(ph_rise_r), .busy_o(), .done_o(ph_r_done)
   );
   cpg_delay_timer #(.CNT_W(CNT_W)) u_ph_f (
      .clk_i(clk_i), .rst_i(rst_i), .start_i(fall_trig), .abort_i(kill | rise_trig),
      .tick_i(tick), .len_i(ph_fall_r), .busy_o(), .done_o(ph_f_done)
   );
   cpg_delay_timer #(.CNT_W(CNT_W)) u_db_r (
      .clk_i(clk_i), .rst_i(rst_i), .start_i(ph_r_done), .abort_i(kill | ph_f_done),
      .tick_i(db_r_tick), .len_i(db_r_len), .busy_o(), .done_o(db_r_done)
   );
   cpg_delay_timer #(.CNT_W(CNT_W)) u_db_f (
      .clk_i(clk_i), .rst_i(rst_i), .start_i(ph_f_done), .abort_i(kill | ph_r_done),
      .tick_i(db_f_tick), .len_i(db_f_len), .busy_o(), .done_o(db_f_done)
   );
   cpg_delay_timer #(.CNT_W(CNT_W)) u_bk_f (
      .clk_i(clk_i), .rst_i(rst_i), .start_i(ph_r_done), .abort_i(kill),
      .tick_i(tick), .len_i(blk_fall_r), .busy_o(bk_f_busy), .done_o()
   );
   cpg_delay_timer #(.CNT_W(CNT_W)) u_bk_r (
      .clk_i(clk_i), .rst_i(rst_i), .start_i(ph_f_done), .abort_i(kill),
      .tick_i(tick), .len_i(blk_rise_r), .busy_o(bk_r_busy), .done_o()
   );

   // Full-bridge direction change holds off the modulated output
   assign dir_start = fb && (fb_rev != fb_dir_r);
   assign dir_len = fb_rev ? (ctrl1_r.fall_db_async ? chain_cyc(db_fall_r) : db_fall_r)
                           : (ctrl1_r.rise_db_async ? chain_cyc(db_rise_r) : db_rise_r);
   assign dir_tick = fb_rev ? db_f_tick : db_r_tick;

   cpg_delay_timer #(.CNT_W(CNT_W)) u_dir (
      .clk_i(clk_i), .rst_i(rst_i), .start_i(dir_start), .abort_i(1'b0),
      .tick_i(dir_tick), .len_i(dir_len), .busy_o(dir_busy), .done_o()
   );

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         fb_dir_r <= 1'b0;
      end else if (fb) begin
         fb_dir_r <= fb_rev;
      end
   end

   // ****************************************************************
   // Waveform state
   // ****************************************************************
   logic pp_sel_r;
   logic [3:0] steer_act_r;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         drive_on_r <= 1'b0;
      end else if (kill || fall_trig) begin
         drive_on_r <= 1'b0;
      end else if (rise_trig) begin
         drive_on_r <= 1'b1;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         prim_r <= 1'b0;
         comp_r <= 1'b1;
      end else if (!ctrl0_r.en) begin
         prim_r <= 1'b0;
         comp_r <= 1'b1;
      end else if (shut_r) begin
         prim_r <= 1'b0;
         comp_r <= 1'b0;
      end else begin
         if (ph_r_done) begin
            comp_r <= 1'b0;
         end
         if (db_r_done) begin
            prim_r <= 1'b1;
         end
         if (ph_f_done) begin
            prim_r <= 1'b0;
         end
         if (db_f_done) begin
            comp_r <= 1'b1;
         end
      end
   end

   // Each new period switches to the other pair
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pp_sel_r <= 1'b1;
      end else if (!ctrl0_r.en) begin
         pp_sel_r <= 1'b1;
      end else if (ph_r_done) begin
         pp_sel_r <= ~pp_sel_r;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         steer_act_r <= 4'h0;
      end else if (mode != CPG_MD_SYNC_STEER || rise_trig) begin
         steer_act_r <= steer_r.steer_en;
      end
   end

   // ****************************************************************
   // Shutdown
   // ****************************************************************
   logic [NUM_SHD-1:0] shd_s1_r;
   logic [NUM_SHD-1:0] shd_s2_r;
   logic fault;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         shd_s1_r <= '0;
         shd_s2_r <= '0;
      end else begin
         shd_s1_r <= shdn_src_i;
         shd_s2_r <= shd_s1_r;
      end
   end

   assign fault = (|(shd_s2_r & shdn_r.src_sel[NUM_SHD-1:0])) | shdn_r.sw_shut;

   // A fault wins over a clear in the same cycle
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         shut_r <= 1'b0;
      end else if (fault) begin
         shut_r <= 1'b1;
      end else if (clr_shut || (shdn_r.auto_restart && rise_evt)) begin
         shut_r <= 1'b0;
      end
   end

   // ****************************************************************
   // Output mapping, steering, polarity and override
   // ****************************************************************
   logic [3:0] data;
   logic modv;

   assign modv = prim_r & ~dir_busy;

   always_comb begin
      case (mode)
         CPG_MD_FB_FWD: data = {modv, 1'b0, 1'b0, 1'b1};
         CPG_MD_FB_REV: data = {1'b0, 1'b1, modv, 1'b0};
         CPG_MD_HALF: data = {comp_r, prim_r, comp_r, prim_r};
         CPG_MD_PUSH_PULL: data = {prim_r & pp_sel_r, prim_r & ~pp_sel_r,
                                   prim_r & pp_sel_r, prim_r & ~pp_sel_r};
         default: data = {4{prim_r}};
      endcase
      if (!ctrl0_r.en) begin
         data = {comp_r, prim_r, comp_r, prim_r};
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         out_r <= 4'h0;
         oe_n_r <= 4'h0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            oe_n_r[i] <= 1'b0;
            if (!steer_act_r[i]) begin
               out_r[i] <= steer_r.static_lvl[i];
            end else if (shut_r) begin
               case (cpg_ovr_t'(shdn_r.ovr[2*i +: 2]))
                  CPG_OVR_HIZ: begin
                     out_r[i] <= 1'b0;
                     oe_n_r[i] <= 1'b1;
                  end
                  CPG_OVR_INACTIVE: out_r[i] <= ctrl1_r.pol[i];
                  CPG_OVR_LOW: out_r[i] <= 1'b0;
                  default: out_r[i] <= 1'b1;
               endcase
            end else begin
               out_r[i] <= data[i] ^ ctrl1_r.pol[i];
            end
         end
      end
   end

   assign out_o = out_r;
   assign out_oe_n_o = oe_n_r;
endmodule
`default_nettype wire

// ===== cpg_pwm_source.sv
// Event source model: one periodic PWM feeding both event inputs
`default_nettype none
module cpg_pwm_source
   import cpg_pkg::*;
#(parameter int PER = 20, parameter int HI = 6)(
   input wire logic clk_i,
   input wire logic rst_i,
   output logic pwm_o
);
   timeunit 1ns;
   timeprecision 100ps;
   int cnt_r;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_r <= 0;
         pwm_o <= 1'b0;
      end else begin
         cnt_r <= cnt_r == PER - 1 ? 0 : cnt_r + 1;
         pwm_o <= cnt_r < HI;
      end
   end
endmodule
`default_nettype wire

// ===== cpg_generator_assertions.sv
// Port checker for the PWM output generator
`default_nettype none
module cpg_generator_assertions
   import cpg_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [5:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic avs_waitrequest_o,
   input wire logic [3:0] out_o
);
   logic [7:0] c0_r, st_r;
   logic [4:0] cnt_r;
   wire tk = avs_write_i && !avs_waitrequest_o;
   wire stw = tk && avs_address_i == CPG_OFF_STEER;
   wire live = cnt_r == 5'h1f && st_r[3:0] == 4'hf;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         c0_r <= 8'h00;
         st_r <= 8'h00;
         cnt_r <= 5'h00;
      end else begin
         if (tk && avs_address_i == CPG_OFF_CTRL0) c0_r <= avs_writedata_i[7:0];
         if (stw) st_r <= avs_writedata_i[7:0];
         cnt_r <= tk ? 5'h00 : cnt_r + {4'h0, cnt_r != 5'h1f};
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence bus_take;
      (avs_read_i || avs_write_i) && avs_waitrequest_o;
   endsequence
   property pairs(logic [7:0] m);
      live && c0_r == m |-> out_o[1:0] == out_o[3:2] && out_o[1:0] != 2'h3;
   endproperty
   a_bus_answer: assert property (bus_take |=> !avs_waitrequest_o) else $error("bus late");
   a_steer_delay: assert property (stw && avs_writedata_i[3:0] == 4'h0
      |-> ##3 out_o == $past(avs_writedata_i[7:4], 3)) else $error("static late");
   a_static_level: assert property (cnt_r == 5'h1f && st_r[3:0] == 4'h0
      |-> out_o == st_r[7:4]) else $error("static wrong");
   a_idle_levels: assert property (live && !c0_r[7]
      |-> out_o == 4'ha) else $error("idle wrong");
   a_fwd_bridge: assert property (live && c0_r == 8'h82
      |-> out_o[2:0] == 3'h1) else $error("forward wrong");
   a_rev_bridge: assert property (live && c0_r == 8'h83
      |-> {out_o[3:2], out_o[0]} == 3'h2) else $error("reverse wrong");
   a_half_pairs: assert property (pairs(8'h84)) else $error("half wrong");
   a_push_pairs: assert property (pairs(8'h85)) else $error("push wrong");
endmodule
bind cpg_generator cpg_generator_assertions i_cpg_generator_assertions (.*);
`default_nettype wire

// ===== test_complementary_pwm_output_generator.sv
// Self-checking bench for the PWM output generator
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; \
   $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
module test_complementary_pwm_output_generator
   import cpg_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_i = 1'b0, rst_i = 1'b1, rd = 1'b0, wr = 1'b0, wq, pwm;
   logic [5:0] adr = 6'h00;
   logic [31:0] wd = 32'h0, rdat, rdv;
   logic [3:0] out, oe_n, flt = 4'h0;
   int n_mismatch = 0, tests_run = 0;
   always #12.5 clk_i = ~clk_i;
   cpg_generator i_cpg_generator (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(adr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hf),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wq), .rise_src_i({7'h00, pwm}),
      .fall_src_i({7'h00, pwm}), .shdn_src_i(flt), .out_o(out), .out_oe_n_o(oe_n));
   cpg_pwm_source i_cpg_pwm_source (.clk_i(clk_i), .rst_i(rst_i), .pwm_o(pwm));
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clk_i);
      {adr, wd, wr, rd} <= {a, d, w, !w};
      do @(posedge clk_i); while (wq !== 1'b0 && ++n < 20);
      rdv = rdat;
      {wr, rd} <= 2'b00;
      if (n >= 20) give_verdict(1'b1);
   endtask
   task automatic t_reset();
      `CHK({out, oe_n}, 8'h00)
      bus(1'b0, 6'h3c, 32'h0);
      `CHK(rdv, 32'h0)
   endtask
   task automatic t_static();
      bus(1'b1, CPG_OFF_STEER, 32'h50);
      repeat (32) @(posedge clk_i);
      `CHK(out, 4'h5)
      bus(1'b0, CPG_OFF_STEER, 32'h0);
      `CHK(rdv, 32'h50)
   endtask
   task automatic t_modes();
      logic [5:0] ev [5] = '{CPG_OFF_RISE_SEL, CPG_OFF_RISE_EDGE, CPG_OFF_FALL_SEL,
         CPG_OFF_FALL_EDGE, CPG_OFF_STEER};
      logic [2:0] md [7] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h2, 3'h3, 3'h4};
      logic [31:0] ex [7] = '{32'h18181818, 32'h18181818, 32'h38183818, 32'h0c0c0c0c,
         32'h18000050, 32'h00501800, 32'h30103010};
      logic [7:0] hc [4];
      foreach (ev[i]) bus(1'b1, ev[i], i < 4 ? 32'h1 : 32'hf);
      foreach (md[m]) begin
         if (m == 6) begin
            // Ten chain elements round up to two cycles
            bus(1'b1, CPG_OFF_DB_RISE, 32'ha);
            bus(1'b1, CPG_OFF_DB_FALL, 32'h2);
            bus(1'b1, CPG_OFF_CTRL1, 32'h10);
         end
         bus(1'b1, CPG_OFF_CTRL0, {24'h0, 5'h10, md[m]});
         repeat (40) @(posedge clk_i);
         hc = '{default: 8'h00};
         repeat (80) begin
            @(posedge clk_i);
            foreach (hc[i]) hc[i] += {7'h00, out[i] === 1'b1};
         end
         `CHK({hc[3], hc[2], hc[1], hc[0]}, ex[m])
      end
   endtask
   task automatic t_shutdown();
      bus(1'b1, CPG_OFF_SHDN, 32'he401);
      flt <= 4'h1;
      repeat (8) @(posedge clk_i);
      `CHK({out, oe_n}, 8'h81)
      bus(1'b0, CPG_OFF_STATUS, 32'h0);
      `CHK(rdv, 32'h81)
      flt <= 4'h0;
      bus(1'b1, CPG_OFF_STATUS, 32'h1);
      bus(1'b0, CPG_OFF_STATUS, 32'h0);
      `CHK({rdv[0], oe_n}, 5'h00)
   endtask
   task automatic t_disabled();
      bus(1'b1, CPG_OFF_CTRL0, 32'h0);
      repeat (32) @(posedge clk_i);
      `CHK(out, 4'ha)
   endtask
   task automatic give_verdict(input logic hang);
      if (hang) n_mismatch++;
      $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_static();
      t_modes();
      t_shutdown();
      t_disabled();
      give_verdict(1'b0);
   end
endmodule
`default_nettype wire
